/* verilog/dcp_pkg.sv */
/*
 * Shared constants and types for the dual bus transceiver protection
 * control: timing counts, register map, mode encoding and carriers.
 * Assumes a 50 MHz system clock; all times are turned into cycles here.
 */
package dcp_pkg;

    // timing
    localparam int unsigned CLK_MHZ         = 50;
    localparam int unsigned DTO_LIMIT_US    = 1200;
    localparam int unsigned DTO_LIMIT_CYC   = DTO_LIMIT_US * CLK_MHZ;
    localparam int unsigned MODE_CHANGE_US  = 20;
    localparam int unsigned MODE_CHANGE_CYC = MODE_CHANGE_US * CLK_MHZ;
    // half the limit, leaving room for pin synchroniser latency
    localparam int unsigned MODE_SETTLE_CYC = MODE_CHANGE_CYC / 2;
    localparam int unsigned MODE_CW         = 10;

    // register map, byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAULT  = 8'h08;
    localparam logic [7:0] REG_DTOCNT = 8'h0c;

    localparam logic [1:0] CTRL_RST     = 2'h0;
    localparam int unsigned CH2_POS     = 8;
    localparam int unsigned FLT_DTO_BIT = 0;
    localparam int unsigned FLT_TSD_BIT = 1;
    localparam int unsigned FLT_UV_BIT  = 2;
    localparam logic [2:0] FLT_RST      = 3'h0;
    localparam logic [7:0] DTOCNT_RST   = 8'h00;

    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef enum logic [3:0] {
        MODE_PROT = 4'h1,
        MODE_CHG  = 4'h2,
        MODE_NORM = 4'h4,
        MODE_STBY = 4'h8
    } dcp_mode_t;

    // raw pin levels, before synchronising
    typedef struct packed {
        logic tx;
        logic tx_drv;
        logic stb;
        logic stb_drv;
        logic bus_dom;
        logic supply_ok;
    } dcp_pin_raw_t;

    // resolved levels seen by a channel
    typedef struct packed {
        logic tx;
        logic stb;
        logic bus_dom;
        logic supply_ok;
    } dcp_chan_in_t;

    // bus line control: dom drives both lines, else bias only
    typedef struct packed {
        logic dom;
        logic bias_mid;
        logic bias_gnd;
    } dcp_bus_ctl_t;

    typedef struct packed {
        logic      drv;
        logic      overtemp_cutoff;
        logic      dominant_hold_guard;
        dcp_mode_t mode;
    } dcp_chan_stat_t;

endpackage

/* verilog/dcp_chan.sv */
/*
 * One transceiver channel: mode machine, dominant hold guard and
 * gating of driver, bias and receive output.
 * Assumes its inputs are already synchronised to clk_sys_i.
 */
`timescale 1ns/1ns
module dcp_chan
    import dcp_pkg::*;
#(
    parameter int unsigned DTO_CYC = DTO_LIMIT_CYC
) (
    // system
    input  wire logic   clk_sys_i,
    input  wire logic   rst_i,
    // resolved pins and controls
    input  dcp_chan_in_t pin_i,
    input  wire logic   tsd_i,
    input  wire logic   force_stb_i,
    // outputs
    output dcp_bus_ctl_t bus_o,
    output logic        rx_o,
    output logic        rx_oe_o,
    output dcp_chan_stat_t stat_o
);

    localparam int unsigned DW = $clog2(DTO_CYC + 1);
    localparam int CHG_MAX = MODE_SETTLE_CYC;

    dcp_mode_t          mode_q;
    dcp_mode_t          mode_d;
    logic [MODE_CW-1:0] settle_q;
    logic [DW-1:0]      dto_cnt_q;
    logic               dto_q;
    dcp_bus_ctl_t       bus_q;
    logic               rx_q;
    logic               rx_oe_q;

    wire want_stby = pin_i.stb | force_stb_i;
    wire settled   = settle_q == MODE_CW'(MODE_SETTLE_CYC - 1);
    wire in_norm   = mode_q == MODE_NORM;
    wire dto_hit   = dto_cnt_q == DW'(DTO_CYC - 1);
    wire rx_live   = (mode_q == MODE_NORM) | (mode_q == MODE_CHG);

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_PROT: mode_d = MODE_CHG;
            MODE_CHG:  if (settled) begin
                mode_d = want_stby ? MODE_STBY : MODE_NORM;
            end
            MODE_NORM: if (want_stby) begin
                mode_d = MODE_CHG;
            end
            MODE_STBY: if (!want_stby) begin
                mode_d = MODE_CHG;
            end
            default:   mode_d = MODE_PROT;
        endcase
        if (!pin_i.supply_ok) begin
            mode_d = MODE_PROT;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q   <= MODE_PROT;
            settle_q <= '0;
        end else begin
            mode_q   <= mode_d;
            settle_q <= (mode_q == MODE_CHG && !settled) ?
                        settle_q + 1'b1 : '0;
        end
    end

    // guard counts any low span in normal mode, so entering normal
    // with tx already low is also caught
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !in_norm || pin_i.tx) begin
            dto_cnt_q <= '0;
            dto_q     <= 1'b0;
        end else begin
            if (!dto_hit) begin
                dto_cnt_q <= dto_cnt_q + 1'b1;
            end
            if (dto_hit) begin
                dto_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bus_q   <= '{dom: 1'b0, bias_mid: 1'b0, bias_gnd: 1'b1};
            rx_q    <= 1'b1;
            rx_oe_q <= 1'b0;
        end else begin
            // low tx is dominant
            bus_q.dom      <= in_norm & ~pin_i.tx & ~dto_q
                              & ~tsd_i;
            bus_q.bias_mid <= rx_live;
            bus_q.bias_gnd <= ~rx_live;
            rx_q           <= rx_live ? ~pin_i.bus_dom
                                      : 1'b1;
            rx_oe_q        <= mode_q != MODE_PROT;
        end
    end

    assign bus_o   = bus_q;
    assign rx_o    = rx_q;
    assign rx_oe_o = rx_oe_q;
    assign stat_o  = '{drv: bus_q.dom, overtemp_cutoff: tsd_i, dominant_hold_guard: dto_q,
                       mode: mode_q};

    dto_fires_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (dto_hit && in_norm && !pin_i.tx && mode_d == MODE_NORM)
        |=> dto_q ##1 !bus_o.dom)
        else $error("dominant guard did not cut the driver");

    dto_release_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (dto_q && pin_i.tx) |=> !dto_q)
        else $error("guard fault not cleared by recessive tx");

    drv_norm_only_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (mode_q != MODE_NORM) |=> !bus_o.dom)
        else $error("driver active outside normal mode");

    tsd_block_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        tsd_i |=> !bus_o.dom)
        else $error("driver active during thermal cutoff");

    rx_follow_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (in_norm && (dto_q || tsd_i))
        |=> (rx_o == !$past(pin_i.bus_dom)) && bus_o.bias_mid)
        else $error("receive path lost during a fault");

    prot_hiz_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !pin_i.supply_ok |-> ##2 (!rx_oe_o && !bus_o.dom
                                  && bus_o.bias_gnd))
        else $error("outputs not released in undervoltage");

    mode_time_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        $rose(mode_q == MODE_CHG)
        |-> ##[1:CHG_MAX] (mode_q != MODE_CHG))
        else $error("mode change took too long");

    stby_bias_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (mode_q == MODE_STBY) |=> (bus_o.bias_gnd && !bus_o.bias_mid
                                   && rx_o))
        else $error("standby bias or receive level wrong");

endmodule

/* verilog/dcp_top.sv */
/*
 * Dual transceiver protection control: two channels, pin synchronisers,
 * thermal cutoff latch with hysteresis and an AHB-Lite register slave.
 * Assumes pins and comparator levels are asynchronous, and that the
 * single AHB master sees hreadyout_o as its hready.
 */
// Overview of operation
// - low level means dominant, high recessive
// - dominant guard runs only in normal mode
// - long dominant tx disables the bus driver
// - recessive tx re-enables driver, clears guard
// - receiver keeps following bus during guard fault
// - overtemperature disables driver and blocks tx
// - thermal fault keeps mid bias, receive path
// - thermal cutoff clears with hysteresis
// - low supply: outputs released, weak pulldown
// - supply good plus settle time: back to normal, or to standby if selected
// - standby biases bus weakly to ground
// - floating tx reads as recessive
// - floating standby select reads as standby
// - high select means standby, low normal
// - mode change completes within 20 us
`timescale 1ns/1ns
module dcp_top
    import dcp_pkg::*;
#(
    parameter int unsigned DTO_CYC = DTO_LIMIT_CYC
) (
    // system
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // controller side, channel 1
    input  wire logic        tx_in_ch1_i,
    input  wire logic        tx_in_ch1_drv_i,
    input  wire logic        low_power_sel_ch1_i,
    input  wire logic        low_power_sel_ch1_drv_i,
    output logic             rx_out_ch1_o,
    output logic             rx_out_ch1_oe_o,
    // controller side, channel 2
    input  wire logic        tx_in_ch2_i,
    input  wire logic        tx_in_ch2_drv_i,
    input  wire logic        low_power_sel_ch2_i,
    input  wire logic        low_power_sel_ch2_drv_i,
    output logic             rx_out_ch2_o,
    output logic             rx_out_ch2_oe_o,
    // bus side
    input  wire logic        bus_dom_ch1_i,
    input  wire logic        bus_dom_ch2_i,
    output dcp_bus_ctl_t     bus_ctl_ch1_o,
    output dcp_bus_ctl_t     bus_ctl_ch2_o,
    // analog monitors
    input  wire logic        supply_ok_ch1_i,
    input  wire logic        supply_ok_ch2_i,
    input  wire logic        overtemp_trip_i,
    input  wire logic        overtemp_release_i
);

    dcp_pin_raw_t [1:0]   raw;
    dcp_pin_raw_t [1:0]   s1_q;
    dcp_pin_raw_t [1:0]   s2_q;
    logic [1:0]           ot1_q;
    logic [1:0]           ot2_q;
    dcp_chan_in_t [1:0]   cin;
    dcp_bus_ctl_t [1:0]   bus_ctl;
    logic [1:0]           rx;
    logic [1:0]           rx_oe;
    dcp_chan_stat_t [1:0] stat;
    dcp_chan_stat_t [1:0] stat_prev_q;
    logic                 tsd_q;
    logic [1:0]           ctrl_q;
    logic [2:0]           fault_q [2];
    logic [2:0]           flt_set [2];
    logic [2:0]           flt_clr [2];
    logic [7:0]           dtocnt_q [2];
    logic                 wr_pend_q;
    logic                 rd_pend_q;
    logic [7:0]           addr_q;
    logic [31:0]          hrdata_q;
    logic                 hreadyout_q;

    assign raw[0] = '{tx: tx_in_ch1_i, tx_drv: tx_in_ch1_drv_i,
                      stb: low_power_sel_ch1_i,
                      stb_drv: low_power_sel_ch1_drv_i,
                      bus_dom: bus_dom_ch1_i,
                      supply_ok: supply_ok_ch1_i};
    assign raw[1] = '{tx: tx_in_ch2_i, tx_drv: tx_in_ch2_drv_i,
                      stb: low_power_sel_ch2_i,
                      stb_drv: low_power_sel_ch2_drv_i,
                      bus_dom: bus_dom_ch2_i,
                      supply_ok: supply_ok_ch2_i};

    // two-stage synchronisers; only s2 and ot2 are read by logic
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            ot1_q <= 2'h0;
            ot2_q <= 2'h0;
        end else begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            ot1_q <= {overtemp_release_i, overtemp_trip_i};
            ot2_q <= ot1_q;
        end
    end

    // trip above threshold, release only well below it; trip wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tsd_q <= 1'b0;
        end else if (ot2_q[0]) begin
            tsd_q <= 1'b1;
        end else if (ot2_q[1]) begin
            tsd_q <= 1'b0;
        end
    end

    // each channel keeps its own mode, guard and gating
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign cin[c] = '{
            tx:        s2_q[c].tx_drv ? s2_q[c].tx : 1'b1,
            stb:       s2_q[c].stb_drv ? s2_q[c].stb : 1'b1,
            bus_dom:   s2_q[c].bus_dom,
            supply_ok: s2_q[c].supply_ok};

        dcp_chan #(
            .DTO_CYC (DTO_CYC)
        ) u_chan (
            .clk_sys_i   (clk_sys_i),
            .rst_i       (rst_i),
            .pin_i       (cin[c]),
            .tsd_i       (tsd_q),
            .force_stb_i (ctrl_q[c]),
            .bus_o       (bus_ctl[c]),
            .rx_o        (rx[c]),
            .rx_oe_o     (rx_oe[c]),
            .stat_o      (stat[c])
        );

        // fault events: rising edge of each condition
        assign flt_set[c][FLT_DTO_BIT] = stat[c].dominant_hold_guard & ~stat_prev_q[c].dominant_hold_guard;
        assign flt_set[c][FLT_TSD_BIT] = stat[c].overtemp_cutoff & ~stat_prev_q[c].overtemp_cutoff;
        assign flt_set[c][FLT_UV_BIT]  = (stat[c].mode == MODE_PROT)
                                  & (stat_prev_q[c].mode != MODE_PROT);
        assign flt_clr[c] = (wr_pend_q && addr_q == REG_FAULT) ?
                            hwdata_i[c*CH2_POS +: 3] : 3'h0;

        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                // matches the channel's reset state: no false event
                stat_prev_q[c] <= '{drv: 1'b0, overtemp_cutoff: 1'b0, dominant_hold_guard: 1'b0,
                                   mode: MODE_PROT};
                fault_q[c]     <= FLT_RST;
                dtocnt_q[c]    <= DTOCNT_RST;
            end else begin
                stat_prev_q[c] <= stat[c];
                // a new event beats a clear in the same cycle
                fault_q[c]     <= (fault_q[c] & ~flt_clr[c]) | flt_set[c];
                // a guard event in the clearing cycle still counts
                if (wr_pend_q && addr_q == REG_DTOCNT) begin
                    dtocnt_q[c] <= DTOCNT_RST
                                   | {7'h00, flt_set[c][FLT_DTO_BIT]};
                end else if (flt_set[c][FLT_DTO_BIT]
                             && dtocnt_q[c] != 8'hff) begin
                    dtocnt_q[c] <= dtocnt_q[c] + 8'h01;
                end
            end
        end
    end

    assign bus_ctl_ch1_o   = bus_ctl[0];
    assign bus_ctl_ch2_o   = bus_ctl[1];
    assign rx_out_ch1_o    = rx[0];
    assign rx_out_ch2_o    = rx[1];
    assign rx_out_ch1_oe_o = rx_oe[0];
    assign rx_out_ch2_oe_o = rx_oe[1];

    // bus slave: writes zero wait, reads take one wait state
    wire acc    = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ)
                  & (hsize_i == HSIZE_WORD);
    wire acc_wr = acc & hwrite_i;
    wire acc_rd = acc & ~hwrite_i;

    wire [31:0] rd_ctrl   = {30'h0, ctrl_q};
    wire [31:0] rd_status = {17'h0, 7'(stat[1]), 1'b0, 7'(stat[0])};
    wire [31:0] rd_fault  = {21'h0, fault_q[1], 5'h0, fault_q[0]};
    wire [31:0] rd_dtocnt = {16'h0, dtocnt_q[1], dtocnt_q[0]};
    wire        hit_ctrl  = addr_q == REG_CTRL;
    wire        hit_stat  = addr_q == REG_STATUS;
    wire        hit_flt   = addr_q == REG_FAULT;
    wire        hit_cnt   = addr_q == REG_DTOCNT;
    wire [31:0] rd_mux    = ({32{hit_ctrl}} & rd_ctrl)
                          | ({32{hit_stat}} & rd_status)
                          | ({32{hit_flt}}  & rd_fault)
                          | ({32{hit_cnt}}  & rd_dtocnt);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_pend_q   <= 1'b0;
            rd_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            hrdata_q    <= 32'h0;
            hreadyout_q <= 1'b1;
        end else begin
            wr_pend_q   <= acc_wr;
            rd_pend_q   <= acc_rd;
            if (acc) begin
                addr_q <= haddr_i[7:0];
            end
            hreadyout_q <= ~acc_rd;
            if (rd_pend_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_pend_q && hit_ctrl) begin
            ctrl_q <= hwdata_i[1:0];
        end
    end

    assign hrdata_o    = hrdata_q;
    assign hreadyout_o = hreadyout_q;
    assign hresp_o     = HRESP_OKAY;

    tsd_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (tsd_q && !ot2_q[1]) |=> tsd_q)
        else $error("thermal cutoff dropped before release");

    tsd_both_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        tsd_q |=> (!bus_ctl_ch1_o.dom && !bus_ctl_ch2_o.dom))
        else $error("a driver stayed on in thermal cutoff");

    tx_float_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (!s2_q[0].tx_drv) [*2] |=> !bus_ctl_ch1_o.dom)
        else $error("floating tx drove the bus");

    stb_float_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (!s2_q[1].stb_drv && s2_q[1].supply_ok
         && stat[1].mode == MODE_NORM)
        |=> stat[1].mode == MODE_CHG)
        else $error("floating select did not leave normal");

    ch_indep_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (!s2_q[0].supply_ok && s2_q[1].supply_ok
         && stat[1].mode == MODE_NORM && !ctrl_q[1] && !cin[1].stb)
        |=> stat[1].mode == MODE_NORM)
        else $error("channel 1 undervoltage disturbed channel 2");

    rd_wait_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        acc_rd |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state missing");

    tx_path_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (stat[0].mode == MODE_NORM && !stat[0].dominant_hold_guard && !tsd_q
         && !cin[0].tx) |=> bus_ctl_ch1_o.dom)
        else $error("dominant tx did not reach the bus");

    rx_mirror_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (stat[1].mode == MODE_NORM)
        |=> (rx_out_ch2_o == !$past(cin[1].bus_dom)))
        else $error("receive output did not mirror the bus");

    rx_drive_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (stat[0].mode == MODE_NORM) |=> rx_out_ch1_oe_o)
        else $error("receive output released in normal mode");

    flt_set_wins_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (flt_set[0] != 3'h0)
        |=> ((fault_q[0] & $past(flt_set[0])) == $past(flt_set[0])))
        else $error("fault event lost");

    flt_clear_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_pend_q && hit_flt && flt_set[1] == 3'h0)
        |=> (fault_q[1] == ($past(fault_q[1]) & ~$past(hwdata_i[10:8]))))
        else $error("fault clear by write went wrong");

    cnt_step_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (flt_set[0][FLT_DTO_BIT] && !hit_cnt && dtocnt_q[0] != 8'hff)
        |=> (dtocnt_q[0] == $past(dtocnt_q[0]) + 8'h01))
        else $error("guard event not counted");

endmodule

/* tb/dcp_bus_model.sv */
/*
 * Bus line model for one channel: wired dominant of this node and of
 * the other nodes. Assumes the bench drives other_dom_i.
 */
`timescale 1ns/1ns
module dcp_bus_model
    import dcp_pkg::*;
(
    // from this node and the rest of the network
    input  dcp_bus_ctl_t ctl_i,
    input  wire logic    other_dom_i,
    // comparator level seen by the node
    output logic         bus_dom_o
);
    // any dominant driver overwrites the recessive bias
    assign bus_dom_o = ctl_i.dom | other_dom_i;
endmodule

/* tb/tb.sv */
/*
 * Self-checking bench for the dual transceiver protection control.
 * Assumes a short guard period parameter and one AHB-Lite master.
 */
`timescale 1ns/1ns
module tb;
    import dcp_pkg::*;
    localparam int DOMINANT_HOLD_GUARD = 20;
    logic         clk = 1'h0;
    logic         rst = 1'h1;
    logic         hsel = 1'h0;
    logic         hwr = 1'h0;
    logic [31:0]  haddr = 32'h0;
    logic [31:0]  hwdata = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic [2:0]   hsize = HSIZE_WORD;
    logic [31:0]  hrdata;
    logic         hrdy;
    logic         hresp;
    // select pins driven, pull-ups only failsafe
    logic tx1 = 1'h1, tx1d = 1'h1, sel1 = 1'h0, sel1d = 1'h1;
    logic tx2 = 1'h1, tx2d = 1'h1, sel2 = 1'h0, sel2d = 1'h1;
    logic sup1 = 1'h1, sup2 = 1'h1, trip = 1'h0, rel = 1'h1;
    logic oth1 = 1'h0, oth2 = 1'h0;
    logic rx1, rx1oe, rx2, rx2oe, bd1, bd2;
    dcp_bus_ctl_t bc1, bc2;
    int           err_count = 0;
    int           checks = 0;
    logic [31:0]  v;

    always #10 clk = ~clk;

    dcp_top #(.DTO_CYC(DOMINANT_HOLD_GUARD)) dcp_top_inst (
        .clk_sys_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwr), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp),
        .tx_in_ch1_i(tx1), .tx_in_ch1_drv_i(tx1d),
        .low_power_sel_ch1_i(sel1), .low_power_sel_ch1_drv_i(sel1d),
        .rx_out_ch1_o(rx1), .rx_out_ch1_oe_o(rx1oe),
        .tx_in_ch2_i(tx2), .tx_in_ch2_drv_i(tx2d),
        .low_power_sel_ch2_i(sel2), .low_power_sel_ch2_drv_i(sel2d),
        .rx_out_ch2_o(rx2), .rx_out_ch2_oe_o(rx2oe),
        .bus_dom_ch1_i(bd1), .bus_dom_ch2_i(bd2),
        .bus_ctl_ch1_o(bc1), .bus_ctl_ch2_o(bc2),
        .supply_ok_ch1_i(sup1), .supply_ok_ch2_i(sup2),
        .overtemp_trip_i(trip), .overtemp_release_i(rel)
    );
    dcp_bus_model dcp_bus_model_inst (
        .ctl_i(bc1), .other_dom_i(oth1), .bus_dom_o(bd1)
    );
    dcp_bus_model dcp_bus_model_inst2 (
        .ctl_i(bc2), .other_dom_i(oth2), .bus_dom_o(bd2)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // hready sampled at each edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'h1 && n < 50);
        if (hrdy !== 1'h1) begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwr <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        v = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'h0, a, 32'h0);
        chk(v, e);
    endtask

    initial begin
        cyc(100000);
        err_count++;
        print_verdict();
    end

    initial begin
        cyc(3);
        rst <= 1'h0;
        cyc(1);
        chk(bc1, 32'h1);
        chk(rx1oe, 32'h0);
        chk(hrdy, 32'h1);
        chk(hresp, 32'h0);
        cyc(1000);
        rdc(REG_STATUS, 32'h0404);
        rdc(REG_CTRL, 32'h0);
        rdc(REG_FAULT, 32'h0);
        rdc(REG_DTOCNT, 32'h0);
        rdc(8'h10, 32'h0);
        // a halfword write must be ignored
        hsize <= 3'h1;
        ahb(1'h1, REG_CTRL, 32'h3);
        hsize <= HSIZE_WORD;
        rdc(REG_CTRL, 32'h0);
        chk(bc1, 32'h2);
        chk(rx1oe, 32'h1);
        chk(rx2oe, 32'h1);
        $display("test reset done");
        // dominant runs stay well under the guard period
        tx1 <= 1'h0;
        cyc(12);
        chk(bc1.dom, 32'h1);
        chk(rx1, 32'h0);
        chk(bc2.dom, 32'h0);
        tx1 <= 1'h1;
        tx2 <= 1'h0;
        cyc(12);
        chk(rx1, 32'h1);
        chk(bc2.dom, 32'h1);
        chk(rx2, 32'h0);
        tx2 <= 1'h1;
        cyc(12);
        rdc(REG_FAULT, 32'h0);
        $display("test polarity done");
        tx1 <= 1'h0;
        cyc(10);
        chk(bc1.dom, 32'h1);
        cyc(30);
        chk(bc1.dom, 32'h0);
        chk(bc1.bias_mid, 32'h1);
        chk(rx1, 32'h1);
        oth1 <= 1'h1;
        cyc(12);
        chk(rx1, 32'h0);
        oth1 <= 1'h0;
        rdc(REG_STATUS, 32'h0414);
        rdc(REG_FAULT, 32'h1);
        rdc(REG_DTOCNT, 32'h1);
        chk(bc2.dom, 32'h0);
        tx1 <= 1'h1;
        cyc(12);
        rdc(REG_STATUS, 32'h0404);
        tx1 <= 1'h0;
        cyc(10);
        chk(bc1.dom, 32'h1);
        tx1 <= 1'h1;
        cyc(12);
        ahb(1'h1, REG_FAULT, 32'h1);
        rdc(REG_FAULT, 32'h0);
        ahb(1'h1, REG_DTOCNT, 32'h0);
        rdc(REG_DTOCNT, 32'h0);
        $display("test guard done");
        trip <= 1'h1;
        rel <= 1'h0;
        cyc(12);
        rdc(REG_STATUS, 32'h2424);
        tx1 <= 1'h0;
        cyc(10);
        chk(bc1, 32'h2);
        tx1 <= 1'h1;
        oth1 <= 1'h1;
        cyc(12);
        chk(rx1, 32'h0);
        oth1 <= 1'h0;
        trip <= 1'h0;
        cyc(12);
        tx1 <= 1'h0;
        cyc(10);
        chk(bc1.dom, 32'h0);
        tx1 <= 1'h1;
        rel <= 1'h1;
        cyc(12);
        tx1 <= 1'h0;
        cyc(10);
        chk(bc1.dom, 32'h1);
        tx1 <= 1'h1;
        cyc(12);
        rdc(REG_FAULT, 32'h0202);
        ahb(1'h1, REG_FAULT, 32'h0202);
        rdc(REG_FAULT, 32'h0);
        $display("test thermal done");
        // floating tx must read recessive
        tx1d <= 1'h0;
        tx1 <= 1'h0;
        cyc(40);
        chk(bc1.dom, 32'h0);
        rdc(REG_FAULT, 32'h0);
        tx1d <= 1'h1;
        tx1 <= 1'h1;
        $display("test floating tx done");
        sel1 <= 1'h1;
        sel2d <= 1'h0;
        cyc(1000);
        rdc(REG_STATUS, 32'h0808);
        chk(bc1, 32'h1);
        chk(bc2, 32'h1);
        oth1 <= 1'h1;
        tx1 <= 1'h0;
        cyc(40);
        chk(rx1, 32'h1);
        chk(bc1.dom, 32'h0);
        rdc(REG_FAULT, 32'h0);
        tx1 <= 1'h1;
        oth1 <= 1'h0;
        sel1 <= 1'h0;
        sel2d <= 1'h1;
        cyc(1000);
        rdc(REG_STATUS, 32'h0404);
        ahb(1'h1, REG_CTRL, 32'h2);
        rdc(REG_CTRL, 32'h2);
        cyc(1000);
        rdc(REG_STATUS, 32'h0804);
        ahb(1'h1, REG_CTRL, 32'h1);
        cyc(1000);
        rdc(REG_STATUS, 32'h0408);
        ahb(1'h1, REG_CTRL, 32'h0);
        cyc(1000);
        $display("test standby done");
        sup1 <= 1'h0;
        cyc(12);
        chk(rx1oe, 32'h0);
        chk(bc1, 32'h1);
        rdc(REG_STATUS, 32'h0401);
        rdc(REG_FAULT, 32'h4);
        sup1 <= 1'h1;
        cyc(1000);
        rdc(REG_STATUS, 32'h0404);
        chk(rx1oe, 32'h1);
        tx1 <= 1'h0;
        cyc(12);
        chk(rx1, 32'h0);
        tx1 <= 1'h1;
        cyc(12);
        $display("test undervoltage done");
        print_verdict();
    end
endmodule
